/* File: rtl/bgl_glue.sv */
// board glue logic: reset button, module detect, resets, watchdog, thermal policy, indicators
//
// Function
// - short button hold gives warm reset
// - long hold raises vector interrupt instead
// - module insert/remove raises vector interrupt
// - control bit resets management controller
// - control bit resets host processor
// - watchdog resets whichever side stops servicing
// - thermal event: software picks shutdown/run, default shutdown
// - shutdown keeps monitoring, reboots when clear
// - locate indicator flashes blue when set
// - port indicator: link on, activity flashes
// - four lanes: green 25G, yellow 10G
// - supply indicator green normal, amber fault
// - fan indicator green when all run
// - system indicator green on good diagnostics
// - management port indicator: link, activity flash
// - host controls i2c component segments
// - forward supply loss to management controller
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
module bgl_glue
	import bgl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC_DEF,
	parameter int N_NIF       = 8,
	parameter int N_FAB       = 8,
	parameter int N_SFP       = 2,
	parameter int N_QSFP      = 4,
	parameter int N_PSU       = 2,
	parameter int N_FAN       = 4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  reset_button_n,
	input  wire logic                  thermal_alarm,
	input  wire logic                  bmc_wdog_kick,
	input  wire logic [N_NIF-1:0]      nif_present,
	input  wire logic [N_FAB-1:0]      fab_present,
	input  wire logic [N_SFP-1:0]      sfp_link,
	input  wire logic [N_SFP-1:0]      sfp_act,
	input  wire logic [4*N_QSFP-1:0]   qsfp_link,
	input  wire logic [4*N_QSFP-1:0]   qsfp_act,
	input  wire logic [4*N_QSFP-1:0]   qsfp_speed_25g,
	input  wire logic [N_PSU-1:0]      psu_ok,
	input  wire logic [N_PSU-1:0]      psu_power_lost,
	input  wire logic [N_FAN-1:0]      fan_ok,
	input  wire logic                  oob_link,
	input  wire logic                  oob_act,
	output logic                       irq,
	output logic                       sys_warm_reset_n,
	output logic                       host_reset_n,
	output logic                       bmc_reset_n,
	output logic                       main_power_en,
	output logic [N_PSU-1:0]           bmc_psu_lost,
	output logic [I2C_SEGS-1:0]        i2c_seg_en,
	output logic                       locate_indicator,
	output logic [N_SFP-1:0]           led_sfp,
	output logic [4*N_QSFP-1:0]        led_qsfp_green,
	output logic [4*N_QSFP-1:0]        led_qsfp_yellow,
	output logic [N_PSU-1:0]           led_psu_green,
	output logic [N_PSU-1:0]           led_psu_amber,
	output logic                       led_fan_green,
	output logic                       led_sys_green,
	output logic                       led_oob
);
	localparam int NQL = 4 * N_QSFP;
	localparam int SW  = 5 + N_NIF + N_FAB + 2 * N_SFP + 3 * NQL + 2 * N_PSU + N_FAN;
	localparam int NP  = 1 + N_NIF + N_FAB;
	localparam int TW  = $clog2(TICK_CYCLES);

	logic [SW-1:0]       sync_q;
	logic                btn_s, therm_s, kick_s, oob_link_s, oob_act_s;
	logic [N_NIF-1:0]    nif_s;
	logic [N_FAB-1:0]    fab_s;
	logic [N_SFP-1:0]    slink_s, sact_s;
	logic [NQL-1:0]      qlink_s, qact_s, q25_s;
	logic [N_PSU-1:0]    psu_ok_s, psu_lost_s;
	logic [N_FAN-1:0]    fan_s;

	// every pin passes two flops before use
	bgl_sync #(.W(SW)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({oob_act, oob_link, fan_ok, psu_power_lost, psu_ok, qsfp_speed_25g, qsfp_act, qsfp_link,
		           sfp_act, sfp_link, fab_present, nif_present, bmc_wdog_kick, thermal_alarm, reset_button_n}),
		.q       (sync_q)
	);
	assign {oob_act_s, oob_link_s, fan_s, psu_lost_s, psu_ok_s, q25_s, qact_s, qlink_s,
	        sact_s, slink_s, fab_s, nif_s, kick_s, therm_s, btn_s} = sync_q;

	// millisecond tick and blink phase
	logic [TW-1:0] tick_cnt_reg;
	logic          tick_reg;
	logic [8:0]    blink_cnt_reg;
	logic          blink_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg  <= '0;
			tick_reg      <= 1'b0;
			blink_cnt_reg <= '0;
			blink_reg     <= 1'b0;
		end else begin
			tick_reg     <= (tick_cnt_reg == TW'(TICK_CYCLES - 1));
			tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 1'b1;
			if (tick_reg) begin
				blink_cnt_reg <= (blink_cnt_reg == 9'(BLINK_MS - 1)) ? '0 : blink_cnt_reg + 1'b1;
				if (blink_cnt_reg == 9'(BLINK_MS - 1))
					blink_reg <= ~blink_reg;
			end
		end
	end

	// axi4-lite slave state
	logic               wr_en;
	logic [7:0]         aw_addr_reg;
	logic [31:0]        w_data_reg;
	logic [3:0]         w_strb_reg;
	logic [31:0]        wmask;
	logic [CTRL_W-1:0]  ctrl_reg;
	logic [ST_W-1:0]    status_reg, mask_reg, st_set;
	logic [VEC_VALID:0] vec_reg;
	logic [15:0]        wdog_to_reg;
	logic [I2C_SEGS-1:0] i2c_sel_reg;
	logic [31:0]        rd_mux;
	logic               rd_hit, wr_hit;
	bgl_therm_t         th_state_reg;

	assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign wr_hit = aw_addr_reg inside {OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_VECTOR, OFS_PRESENT,
	                                    OFS_WDOG_TO, OFS_WDOG_KICK, OFS_I2C_SEL, OFS_HEALTH};

	// address and data are taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read mux; unused bits read as zero
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_CTRL:      rd_mux = 32'(ctrl_reg);
			OFS_STATUS:    rd_mux = 32'(status_reg);
			OFS_MASK:      rd_mux = 32'(mask_reg);
			OFS_VECTOR:    rd_mux = 32'(vec_reg);
			OFS_PRESENT:   rd_mux = 32'({fab_s, nif_s});
			OFS_WDOG_TO:   rd_mux = 32'(wdog_to_reg);
			OFS_WDOG_KICK: rd_mux = '0;
			OFS_I2C_SEL:   rd_mux = 32'(i2c_sel_reg);
			OFS_HEALTH:    rd_mux = 32'({fan_s, psu_ok_s, therm_s, th_state_reg});
			default:       rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// software settings, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg    <= CTRL_RESET;
			mask_reg    <= MASK_RESET;
			wdog_to_reg <= 16'(WDOG_DEF_MS);
			i2c_sel_reg <= I2C_SEL_RESET;
		end else if (wr_en) begin
			unique case (aw_addr_reg)
				OFS_CTRL:    ctrl_reg    <= (ctrl_reg & ~wmask[CTRL_W-1:0]) | (w_data_reg[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
				OFS_MASK:    mask_reg    <= (mask_reg & ~wmask[ST_W-1:0]) | (w_data_reg[ST_W-1:0] & wmask[ST_W-1:0]);
				OFS_WDOG_TO: wdog_to_reg <= (wdog_to_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
				OFS_I2C_SEL: i2c_sel_reg <= (i2c_sel_reg & ~wmask[I2C_SEGS-1:0])
					| (w_data_reg[I2C_SEGS-1:0] & wmask[I2C_SEGS-1:0]);
				default: ;
			endcase
		end
	end

	logic        btn_db_reg;
	logic [4:0]  deb_cnt_reg;
	logic [13:0] hold_cnt_reg;
	logic        btn_long, btn_short;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_db_reg  <= 1'b0;
			deb_cnt_reg <= '0;
		end else if (btn_db_reg == !btn_s) begin
			deb_cnt_reg <= '0;
		end else if (tick_reg) begin
			deb_cnt_reg <= deb_cnt_reg + 1'b1;
			if (deb_cnt_reg == 5'(DEBOUNCE_MS - 1)) begin
				btn_db_reg  <= !btn_s;
				deb_cnt_reg <= '0;
			end
		end
	end

	// hold time in ms, saturating past the limit
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hold_cnt_reg <= '0;
		else if (!btn_db_reg)
			hold_cnt_reg <= btn_short | btn_long ? '0 : hold_cnt_reg;
		else if (tick_reg && hold_cnt_reg <= 14'(LONG_PRESS_MS))
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
	end

	// release edge decides; counter is cleared the cycle after
	logic btn_db_d_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			btn_db_d_reg <= 1'b0;
		else
			btn_db_d_reg <= btn_db_reg;
	end
	assign btn_short = btn_db_d_reg && !btn_db_reg && hold_cnt_reg <= 14'(LONG_PRESS_MS);
	assign btn_long  = btn_db_d_reg && !btn_db_reg && hold_cnt_reg > 14'(LONG_PRESS_MS);

	// module presence change, reported per port
	logic [N_NIF-1:0] nif_prev_reg;
	logic [N_FAB-1:0] fab_prev_reg;
	logic [NP-1:0]    pend_reg, pend_take, pend_new;
	logic [7:0]       vec_code;
	logic             vec_found;
	logic             vec_ack;
	assign pend_new = {fab_s ^ fab_prev_reg, nif_s ^ nif_prev_reg, btn_long};
	assign vec_ack  = wr_en && aw_addr_reg == OFS_VECTOR;

	// lowest pending index wins; code is class and port index
	always_comb begin
		pend_take = '0;
		vec_code  = '0;
		vec_found = 1'b0;
		for (int i = 0; i < NP; i++) begin
			if (pend_reg[i] && !vec_found) begin
				vec_found    = 1'b1;
				pend_take[i] = 1'b1;
				if (i == 0)
					vec_code = {VC_BUTTON, 6'h00};
				else if (i <= N_NIF)
					vec_code = {VC_NIF, 6'(i - 1)};
				else
					vec_code = {VC_FAB, 6'(i - 1 - N_NIF)};
			end
		end
		if (vec_reg[VEC_VALID])
			pend_take = '0;
	end

	// one code held until acknowledged; new events queue behind it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nif_prev_reg <= '0;
			fab_prev_reg <= '0;
			pend_reg     <= '0;
			vec_reg      <= '0;
		end else begin
			nif_prev_reg <= nif_s;
			fab_prev_reg <= fab_s;
			pend_reg     <= (pend_reg & ~pend_take) | pend_new;
			if (!vec_reg[VEC_VALID] && vec_found)
				vec_reg <= {1'b1, vec_code};
			else if (vec_ack)
				vec_reg <= '0;
		end
	end

	// two watchdogs: index 0 host (register kick), 1 controller (pin kick)
	logic        kick_d_reg;
	logic [1:0]  wd_kick, wd_expire;
	logic [15:0] wd_cnt_reg [2];
	assign wd_kick[0] = wr_en && aw_addr_reg == OFS_WDOG_KICK && w_data_reg[0];
	assign wd_kick[1] = kick_s && !kick_d_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kick_d_reg <= 1'b0;
			wd_cnt_reg <= '{2{16'(WDOG_DEF_MS)}};
		end else begin
			kick_d_reg <= kick_s;
			for (int k = 0; k < 2; k++) begin
				if (!ctrl_reg[CTRL_WDOG_EN] || wd_kick[k] || wd_expire[k])
					wd_cnt_reg[k] <= wdog_to_reg;
				else if (tick_reg)
					wd_cnt_reg[k] <= wd_cnt_reg[k] - 1'b1;
			end
		end
	end
	assign wd_expire[0] = ctrl_reg[CTRL_WDOG_EN] && tick_reg && wd_cnt_reg[0] == '0;
	assign wd_expire[1] = ctrl_reg[CTRL_WDOG_EN] && tick_reg && wd_cnt_reg[1] == '0;

	// thermal policy, shutdown unless software chose run
	logic [6:0] warm_cnt_reg, host_cnt_reg, bmc_cnt_reg;
	logic       therm_d_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			th_state_reg <= TH_RUN;
			therm_d_reg  <= 1'b0;
		end else begin
			therm_d_reg <= therm_s;
			unique case (th_state_reg)
				TH_RUN:  if (therm_s && !ctrl_reg[CTRL_THERM_RUN]) th_state_reg <= TH_OFF;
				TH_OFF:  if (!therm_s) th_state_reg <= TH_BOOT;
				TH_BOOT: if (warm_cnt_reg == '0 && !therm_s) th_state_reg <= TH_RUN;
			endcase
		end
	end

	// reset pulse timers in ms; a new start restarts the pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warm_cnt_reg <= '0;
			host_cnt_reg <= '0;
			bmc_cnt_reg  <= '0;
		end else begin
			if (btn_short || (th_state_reg == TH_OFF && !therm_s))
				warm_cnt_reg <= 7'(RST_PULSE_MS);
			else if (tick_reg && warm_cnt_reg != '0)
				warm_cnt_reg <= warm_cnt_reg - 1'b1;
			if (wd_expire[0])
				host_cnt_reg <= 7'(RST_PULSE_MS);
			else if (tick_reg && host_cnt_reg != '0)
				host_cnt_reg <= host_cnt_reg - 1'b1;
			if (wd_expire[1])
				bmc_cnt_reg <= 7'(RST_PULSE_MS);
			else if (tick_reg && bmc_cnt_reg != '0)
				bmc_cnt_reg <= bmc_cnt_reg - 1'b1;
		end
	end

	// sticky status, set beats a same-cycle write-one clear
	assign st_set = {therm_s && !therm_d_reg, wd_expire[1], wd_expire[0], !vec_reg[VEC_VALID] && vec_found};
	always_ff @(posedge aclk) begin
		if (!aresetn)
			status_reg <= '0;
		else if (wr_en && aw_addr_reg == OFS_STATUS)
			status_reg <= (status_reg & ~(w_data_reg[ST_W-1:0] & wmask[ST_W-1:0])) | st_set;
		else
			status_reg <= status_reg | st_set;
	end

	// resets and power; the controller stays up in shutdown since it monitors temperature
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq              <= 1'b0;
			sys_warm_reset_n <= 1'b0;
			host_reset_n     <= 1'b0;
			bmc_reset_n      <= 1'b0;
			main_power_en    <= 1'b0;
			bmc_psu_lost     <= '0;
			i2c_seg_en       <= '0;
		end else begin
			irq              <= |(status_reg & mask_reg);
			sys_warm_reset_n <= warm_cnt_reg == '0;
			host_reset_n     <= !(ctrl_reg[CTRL_HOST_RST] || host_cnt_reg != '0 || warm_cnt_reg != '0
			                      || th_state_reg != TH_RUN);
			bmc_reset_n      <= !(ctrl_reg[CTRL_BMC_RST] || bmc_cnt_reg != '0 || warm_cnt_reg != '0);
			main_power_en    <= th_state_reg != TH_OFF;
			bmc_psu_lost     <= psu_lost_s;
			i2c_seg_en       <= i2c_sel_reg;
		end
	end

	// indicators; activity blanks a lit lamp on the blink phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			locate_indicator <= 1'b0;
			led_sfp          <= '0;
			led_qsfp_green   <= '0;
			led_qsfp_yellow  <= '0;
			led_psu_green    <= '0;
			led_psu_amber    <= '0;
			led_fan_green    <= 1'b0;
			led_sys_green    <= 1'b0;
			led_oob          <= 1'b0;
		end else begin
			locate_indicator <= ctrl_reg[CTRL_LOCATE] && blink_reg;
			led_sfp          <= slink_s & ~(sact_s & {N_SFP{blink_reg}});
			led_qsfp_green   <= qlink_s & q25_s & ~(qact_s & {NQL{blink_reg}});
			led_qsfp_yellow  <= qlink_s & ~q25_s & ~(qact_s & {NQL{blink_reg}});
			led_psu_green    <= psu_ok_s;
			led_psu_amber    <= ~psu_ok_s;
			led_fan_green    <= &fan_s;
			led_sys_green    <= ctrl_reg[CTRL_DIAG_OK];
			led_oob          <= oob_link_s && !(oob_act_s && blink_reg);
		end
	end
endmodule : bgl_glue

/* File: include/bgl_pkg.sv */
// constants, register map and types of the board glue logic controller
package bgl_pkg;
	// clock and time base
	localparam int          CLK_HZ         = 125_000_000;
	localparam int          MS_PER_S       = 1000;
	localparam int          TICK_CYC_DEF   = CLK_HZ / MS_PER_S;
	localparam int          LONG_PRESS_S   = 10;
	localparam int          LONG_PRESS_MS  = LONG_PRESS_S * MS_PER_S;
	localparam int          DEBOUNCE_MS    = 20;
	localparam int          RST_PULSE_MS   = 100;
	localparam int          BLINK_MS       = 250;
	localparam int          WDOG_DEF_MS    = 30000;
	// register offsets (byte addresses)
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_STATUS     = 8'h04;
	localparam logic [7:0]  OFS_MASK       = 8'h08;
	localparam logic [7:0]  OFS_VECTOR     = 8'h0C;
	localparam logic [7:0]  OFS_PRESENT    = 8'h10;
	localparam logic [7:0]  OFS_WDOG_TO    = 8'h14;
	localparam logic [7:0]  OFS_WDOG_KICK  = 8'h18;
	localparam logic [7:0]  OFS_I2C_SEL    = 8'h1C;
	localparam logic [7:0]  OFS_HEALTH     = 8'h20;
	// control fields
	localparam int          CTRL_BMC_RST   = 0;
	localparam int          CTRL_HOST_RST  = 1;
	localparam int          CTRL_THERM_RUN = 2;
	localparam int          CTRL_LOCATE    = 3;
	localparam int          CTRL_WDOG_EN   = 4;
	localparam int          CTRL_DIAG_OK   = 5;
	localparam int          CTRL_W         = 6;
	localparam logic [5:0]  CTRL_RESET     = 6'h00;
	// status / mask fields
	localparam int          ST_VEC         = 0;
	localparam int          ST_WD_HOST     = 1;
	localparam int          ST_WD_BMC      = 2;
	localparam int          ST_THERM       = 3;
	localparam int          ST_W           = 4;
	localparam logic [3:0]  MASK_RESET     = 4'h0;
	// vector code layout: valid, class, index
	localparam int          VEC_VALID      = 8;
	localparam logic [1:0]  VC_BUTTON      = 2'h0;
	localparam logic [1:0]  VC_NIF         = 2'h1;
	localparam logic [1:0]  VC_FAB         = 2'h2;
	// i2c downstream segments: psu, fan, optics, nvm
	localparam int          I2C_SEGS       = 4;
	localparam logic [3:0]  I2C_SEL_RESET  = 4'h0;
	// axi responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {TH_RUN, TH_OFF, TH_BOOT} bgl_therm_t;
endpackage : bgl_pkg

/* File: rtl/bgl_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module bgl_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : bgl_sync

/* File: bench/bgl_assertions.sv */
// concurrent checks on the board glue logic ports
`timescale 1ns/100ps
module bgl_assertions
	import bgl_pkg::*;
#(
	parameter int N_PSU = 2,
	parameter int N_FAN = 4
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic             thermal_alarm,
	input wire logic             main_power_en,
	input wire logic             sys_warm_reset_n,
	input wire logic             host_reset_n,
	input wire logic             bmc_reset_n,
	input wire logic [N_PSU-1:0] psu_ok,
	input wire logic [N_PSU-1:0] psu_power_lost,
	input wire logic [N_PSU-1:0] led_psu_amber,
	input wire logic [N_PSU-1:0] bmc_psu_lost,
	input wire logic [N_FAN-1:0] fan_ok,
	input wire logic             led_fan_green
);
	logic [2:0] up_reg;
	// settle count: synchroniser stages still hold reset values just after release
	always_ff @(posedge aclk) begin
		if (!aresetn) up_reg <= 3'h0;
		else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_b_follows_aw: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid)
		else $error("write answer late");
	chk_b_then_ready: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
	chk_r_follows_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_r_then_ready: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened");
	chk_power_off_cause: assert property ($fell(main_power_en) |-> $past(thermal_alarm, 2))
		else $error("main power dropped without alarm");
	chk_warm_all_low: assert property ($fell(sys_warm_reset_n) |-> ##1 (!host_reset_n && !bmc_reset_n)[*4])
		else $error("warm reset misses a side");
	chk_psu_amber_lamp: assert property ((up_reg == 3'h7 && $stable(psu_ok))[*5] |-> led_psu_amber == ~psu_ok)
		else $error("supply lamp wrong");
	chk_psu_lost_fwd: assert property ((up_reg == 3'h7 && $stable(psu_power_lost))[*5]
		|-> bmc_psu_lost == psu_power_lost)
		else $error("supply loss not forwarded");
	chk_fan_all_ok: assert property ((up_reg == 3'h7 && $stable(fan_ok))[*5] |-> led_fan_green == &fan_ok)
		else $error("fan lamp wrong");
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_warm: cover property ($fell(sys_warm_reset_n));
	cov_therm: cover property ($fell(main_power_en));
endmodule : bgl_assertions

bind bgl_glue bgl_assertions #(.N_PSU(N_PSU), .N_FAN(N_FAN)) u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .thermal_alarm,
	.main_power_en, .sys_warm_reset_n, .host_reset_n, .bmc_reset_n, .psu_ok, .psu_power_lost,
	.led_psu_amber, .bmc_psu_lost, .fan_ok, .led_fan_green
);

/* File: bench/bgl_bmc_model.sv */
// management controller model: services its watchdog pin at a steady rate
`timescale 1ns/100ps
module bgl_bmc_model #(
	parameter int KICK_CYC = 30
) (
	input wire logic aclk,
	input wire logic bmc_reset_n,
	output logic     kick
);
	int cnt;
	// periodic service
	// a controller held in reset services nothing, so the count restarts
	always @(posedge aclk) begin
		if (!bmc_reset_n) begin
			cnt <= 0;
			kick <= 1'b0;
		end else begin
			cnt <= (cnt == KICK_CYC - 1) ? 0 : cnt + 1;
			kick <= (cnt == KICK_CYC - 1);
		end
	end
endmodule : bgl_bmc_model

/* File: bench/tb_top.sv */
// self-checking bench for the board glue logic controller
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
`define TO(c) if (c) begin n_errors++; summarize(); end
`define WT(s, v, lim) begin for (k = 0; k < (lim) && (s) !== (v); k++) @(posedge aclk); `TO(k >= (lim)) `CHK(s, v) end
module tb_top;
	import bgl_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_button_n, thermal_alarm;
	logic        bmc_wdog_kick, oob_link, oob_act, irq, sys_warm_reset_n, host_reset_n, bmc_reset_n;
	logic        main_power_en, locate_indicator, led_fan_green, led_sys_green, led_oob;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, nif_present, fab_present;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sfp_link, sfp_act, psu_ok, psu_power_lost, bmc_psu_lost;
	logic [1:0]  led_sfp, led_psu_green, led_psu_amber;
	logic [15:0] qsfp_link, qsfp_act, qsfp_speed_25g, led_qsfp_green, led_qsfp_yellow;
	logic [3:0]  s_axi_wstrb, fan_ok, i2c_seg_en;
	int          n_errors, check_count, k, i;
	logic [15:0] ev [3] = '{16'h0400, 16'h0402, 16'h0002};
	logic [31:0] vx [3] = '{32'h0000_0142, 32'h0000_0181, 32'h0000_0142};
	bgl_glue #(.TICK_CYCLES(10)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.reset_button_n, .thermal_alarm, .bmc_wdog_kick, .nif_present, .fab_present, .sfp_link, .sfp_act,
		.qsfp_link, .qsfp_act, .qsfp_speed_25g, .psu_ok, .psu_power_lost, .fan_ok, .oob_link, .oob_act,
		.irq, .sys_warm_reset_n, .host_reset_n, .bmc_reset_n, .main_power_en, .bmc_psu_lost, .i2c_seg_en,
		.locate_indicator, .led_sfp, .led_qsfp_green, .led_qsfp_yellow, .led_psu_green, .led_psu_amber,
		.led_fan_green, .led_sys_green, .led_oob
	);
	bgl_bmc_model u_bmc (.aclk, .bmc_reset_n, .kick(bmc_wdog_kick));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic summarize();
		$display("mismatches=%0d comparisons=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		`TO(n == 100)
		`CHK(s_axi_bresp, r)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		`TO(n == 100)
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, r)
	endtask : rd
	initial begin
		{aresetn, reset_button_n, thermal_alarm, oob_link, oob_act, s_axi_wstrb} = 9'h0AF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, nif_present, fab_present} = '0;
		{sfp_link, sfp_act, psu_ok, psu_power_lost, fan_ok} = {2'h3, 2'h0, 2'h1, 2'h1, 4'h7};
		{qsfp_link, qsfp_act, qsfp_speed_25g} = {16'hFFFF, 16'h0000, 16'h00FF};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_WDOG_TO, 32'h0000_7530);
		rd(OFS_MASK, 32'h0);
		rd(8'h24, 32'h0, RESP_SLVERR);
		wr(8'h24, 32'h1, RESP_SLVERR);
		`CHK(led_sfp, 2'h3)
		`CHK({led_qsfp_green, led_qsfp_yellow}, 32'h00FF_FF00)
		`CHK({led_oob, led_psu_amber, led_psu_green, led_fan_green}, 6'h32)
		// insertion, second class, then removal; each held until acknowledged
		wr(OFS_MASK, 32'h1);
		for (i = 0; i < 3; i++) begin
			{nif_present, fab_present} <= ev[i];
			`WT(irq, 1'b1, 40)
			rd(OFS_VECTOR, vx[i]);
			wr(OFS_VECTOR, 32'h0);
			rd(OFS_VECTOR, 32'h0);
			wr(OFS_STATUS, 32'h1);
			`WT(irq, 1'b0, 10)
		end
		wr(OFS_CTRL, 32'h2);
		`WT(host_reset_n, 1'b0, 5)
		wr(OFS_CTRL, 32'h1);
		`WT(bmc_reset_n, 1'b0, 5)
		`WT(host_reset_n, 1'b1, 5)
		wr(OFS_CTRL, 32'h28);
		`WT(bmc_reset_n, 1'b1, 5)
		wr(OFS_I2C_SEL, 32'hA);
		`WT(i2c_seg_en, 4'hA, 5)
		`WT(led_sys_green, 1'b1, 5)
		`WT(locate_indicator, 1'b1, 3000)
		`WT(locate_indicator, 1'b0, 3000)
		{fan_ok, psu_ok, psu_power_lost, sfp_link, oob_link, sfp_act, qsfp_act} <= {10'h3F1, 1'b0, 18'h3FFFF};
		`WT(led_fan_green, 1'b1, 10)
		`WT(led_sfp[1], 1'b0, 10)
		`WT(led_oob, 1'b0, 10)
		`WT(led_sfp[0], 1'b0, 3000)
		// host never services its watchdog, the controller model does
		wr(OFS_CTRL, 32'h0);
		wr(OFS_WDOG_TO, 32'h4);
		wr(OFS_MASK, 32'h6);
		wr(OFS_CTRL, 32'h10);
		`WT(host_reset_n, 1'b0, 200)
		`WT(irq, 1'b1, 10)
		wr(OFS_CTRL, 32'h0);
		rd(OFS_STATUS, 32'h2);
		wr(OFS_STATUS, 32'hF);
		wr(OFS_MASK, 32'h8);
		thermal_alarm <= 1'b1;
		`WT(main_power_en, 1'b0, 20)
		`WT(irq, 1'b1, 20)
		`CHK(bmc_reset_n, 1'b1)
		thermal_alarm <= 1'b0;
		`WT(sys_warm_reset_n, 1'b0, 50)
		`WT(main_power_en, 1'b1, 1500)
		`WT(sys_warm_reset_n, 1'b1, 1500)
		wr(OFS_STATUS, 32'hF);
		wr(OFS_CTRL, 32'h4);
		thermal_alarm <= 1'b1;
		`WT(irq, 1'b1, 20)
		`CHK(main_power_en, 1'b1)
		thermal_alarm <= 1'b0;
		// a short glitch must not count as a press
		reset_button_n <= 1'b0;
		repeat (5) @(posedge aclk);
		reset_button_n <= 1'b1;
		repeat (300) @(posedge aclk);
		`CHK(sys_warm_reset_n, 1'b1)
		reset_button_n <= 1'b0;
		repeat (400) @(posedge aclk);
		reset_button_n <= 1'b1;
		`WT(sys_warm_reset_n, 1'b0, 400)
		summarize();
	end
endmodule : tb_top
